// [hw/opctl_pkg.sv]
// shared constants for the operational control register bank
package opctl_pkg;

	// ------------------------------------------------------------
	// register indices (byte address on the bus is four times these)
	// ------------------------------------------------------------
	localparam logic [11:0] PROFILE_FIRST_BASE = 12'h700;
	localparam logic [11:0] PROFILE_SECOND_BASE = 12'h740;
	localparam logic [11:0] PROFILE_THIRD_BASE = 12'h780;
	localparam logic [11:0] PROFILE_FOURTH_BASE = 12'h7C0;
	localparam logic [5:0] PROFILE_LAST_OFS = 6'h26;
	localparam int PROFILE_BYTES = 39;
	localparam int PROFILE_COUNT = 4;
	localparam logic [11:0] GENERAL_POWER_DOWN_IDX = 12'hA00;
	localparam logic [11:0] LOOP_MODE_CONTROL_IDX = 12'hA01;

	// ------------------------------------------------------------
	// general power-down fields
	// ------------------------------------------------------------
	localparam int PD_SOFT_RESET_BIT = 7;
	localparam int PD_OSC_BIT = 6;
	localparam int PD_SYSTEM_CLOCK_INPUT_BIT = 5;
	localparam int PD_REF_BIT = 4;
	localparam int PD_TDC_BIT = 3;
	localparam int PD_OUTPUT_ANALOG_PLL_BIT = 2;
	localparam int PD_DIST_BIT = 1;
	localparam int PD_FULL_BIT = 0;
	localparam logic [7:0] GENERAL_POWER_DOWN_RESET = 8'h00;

	// ------------------------------------------------------------
	// loop mode fields
	// ------------------------------------------------------------
	localparam int LM_HOLDOVER_BIT = 6;
	localparam int LM_FREERUN_BIT = 5;
	localparam int LM_MODE_LSB = 2;
	localparam int LM_REF_LSB = 0;
	localparam logic [7:0] LOOP_MODE_WRITE_MASK = 8'h7F;
	localparam logic [7:0] LOOP_MODE_CONTROL_RESET = 8'h00;

	typedef enum logic [2:0] {
		SW_AUTO_REVERTIVE = 3'b000,
		SW_AUTO_NONREVERTIVE = 3'b001,
		SW_MANUAL_FALLBACK = 3'b010,
		SW_MANUAL_HOLDOVER = 3'b011,
		SW_FULL_MANUAL = 3'b100,
		SW_UNUSED = 3'b111
	} switch_mode_e;

	typedef enum logic [1:0] {
		TW_LOOP = 2'b00,
		TW_HOLDOVER = 2'b01,
		TW_FREERUN = 2'b10
	} tuning_src_e;

	// reset image of one profile, offset 0x00 at the left
	localparam logic [0:38][7:0] PROFILE_RESET = {
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hF4,
		8'h01, 8'h00, 8'hC5, 8'h00, 8'h00, 8'h6B, 8'h07, 8'h00,
		8'h04, 8'h00, 8'h00, 8'h05, 8'h00, 8'h00, 8'hBC, 8'h02,
		8'h0A, 8'h0A, 8'hBC, 8'h02, 8'h00, 8'h0A, 8'h0A
	};

endpackage

// [hw/operational_control_registers.sv]
// operational control register bank with four separately stored reference profiles
// Function
// - second profile at 0x0740..0x0766, same layout
// - third profile at 0x0780..0x07A6, same layout
// - fourth profile at 0x07C0..0x07E6, same layout
// - power-down bit 7: soft reset, keep registers
// - bit 6 sleeps the oscillator
// - bit 5 sleeps system clock and multiplier
// - bit 4 sleeps all reference inputs
// - bit 3 sleeps the time-to-digital converter
// - bit 2 sleeps the output analog PLL
// - bit 1 sleeps clock distribution outputs
// - bit 0 sleeps the whole device
// - loop mode bit 5 forces user free run
// - free run uses free-run tuning word
// - free run overrides holdover request
// - loop mode bits 4:2 pick switchover mode
// - mode codes decoded, 101-111 unused
// - manual modes take two-bit user reference
`timescale 1ns/100ps

module operational_control_registers
	import opctl_pkg::*;
#(
	parameter int TW_W = 48,
	parameter int ADR_W = 14
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone classic slave
	input wire logic [ADR_W-1:0] adr_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	input wire logic [3:0] sel_i,
	input wire logic we_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	output logic ack_o,
	// profile lookup for the loop logic
	input wire logic [5:0] profile_ofs_i,
	output logic [7:0] profile_dat_o,
	// reference switching
	input wire logic [1:0] auto_ref_i,
	output logic [2:0] switch_mode_o,
	output logic switch_mode_valid_o,
	output logic manual_ref_o,
	output logic [1:0] active_ref_o,
	// oscillator steering
	input wire logic [TW_W-1:0] loop_tuning_word_i,
	input wire logic [TW_W-1:0] holdover_tuning_word_i,
	input wire logic [TW_W-1:0] freerun_tuning_word_i,
	output logic [1:0] tuning_src_o,
	output logic [TW_W-1:0] osc_tuning_word_o,
	output logic force_unlock_o,
	// power control
	output logic soft_reset_o,
	output logic osc_sleep_o,
	output logic system_clock_input_sleep_o,
	output logic ref_sleep_o,
	output logic tdc_sleep_o,
	output logic output_analog_pll_sleep_o,
	output logic dist_sleep_o,
	output logic device_sleep_o
);
	import opctl_pkg::*;

	// elaboration-time refusal of widths the decode cannot serve
	if (TW_W < 1 || ADR_W < 14) begin : g_param_check
		$error("operational_control_registers: unsupported parameter values");
	end

	// ------------------------------------------------------------
	// address decode
	// ------------------------------------------------------------
	// one match function serves the bus and keeps all four profiles on one layout
	function automatic logic profile_hit(input logic [11:0] idx, output logic [1:0] num, output logic [5:0] ofs);
		logic hit;
		hit = 1'b0;
		num = 2'd0;
		ofs = 6'd0;
		if (idx[11:8] == PROFILE_FIRST_BASE[11:8] && idx[5:0] <= PROFILE_LAST_OFS) begin
			hit = 1'b1;
			num = idx[7:6];
			ofs = idx[5:0];
		end
		return hit;
	endfunction

	logic [11:0] idx;
	logic aligned;
	logic prof_hit;
	logic [1:0] prof_num;
	logic [5:0] prof_ofs;
	logic pd_hit;
	logic lm_hit;
	logic bus_req;
	logic wr_en;

	assign idx = adr_i[13:2];
	// a shift rather than a part-select keeps the default width legal
	assign aligned = (adr_i[1:0] == 2'b00) && ((adr_i >> 14) == '0);
	assign bus_req = cyc_i && stb_i && !ack_o;
	assign wr_en = bus_req && we_i && sel_i[0];

	always_comb begin
		prof_hit = profile_hit(idx, prof_num, prof_ofs) && aligned;
		pd_hit = aligned && (idx == GENERAL_POWER_DOWN_IDX);
		lm_hit = aligned && (idx == LOOP_MODE_CONTROL_IDX);
	end

	// ------------------------------------------------------------
	// storage
	// ------------------------------------------------------------
	logic [7:0] profile_q [PROFILE_COUNT][PROFILE_BYTES];
	logic [7:0] power_down_q;
	logic [7:0] loop_mode_q;

	// profiles 1..3 share the first profile's image and offsets
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int p = 0; p < PROFILE_COUNT; p++) begin
				for (int b = 0; b < PROFILE_BYTES; b++) begin
					profile_q[p][b] <= PROFILE_RESET[b];
				end
			end
		end else if (wr_en && prof_hit) begin
			profile_q[prof_num][prof_ofs] <= dat_i[7:0];
		end
	end

	// soft reset leaves every stored value alone; only rst_i or a bus write changes a bit
	always_ff @(posedge clk_i) begin
		if (rst_i)
			power_down_q <= GENERAL_POWER_DOWN_RESET;
		else if (wr_en && pd_hit)
			power_down_q <= dat_i[7:0];
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			loop_mode_q <= LOOP_MODE_CONTROL_RESET;
		else if (wr_en && lm_hit)
			loop_mode_q <= dat_i[7:0] & LOOP_MODE_WRITE_MASK;
	end

	// ------------------------------------------------------------
	// bus answer
	// ------------------------------------------------------------
	// every access answers in one cycle; unmapped reads give zero, writes vanish
	always_ff @(posedge clk_i) begin
		if (rst_i)
			ack_o <= 1'b0;
		else
			ack_o <= bus_req;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			dat_o <= 32'h0000_0000;
		else if (bus_req && !we_i) begin
			if (prof_hit)
				dat_o <= {24'h00_0000, profile_q[prof_num][prof_ofs]};
			else if (pd_hit)
				dat_o <= {24'h00_0000, power_down_q};
			else if (lm_hit)
				dat_o <= {24'h00_0000, loop_mode_q};
			else
				dat_o <= 32'h0000_0000;
		end
	end

	// ------------------------------------------------------------
	// switchover mode and reference choice
	// ------------------------------------------------------------
	function automatic logic mode_is_manual(input logic [2:0] m);
		return (m == SW_MANUAL_FALLBACK) || (m == SW_MANUAL_HOLDOVER) || (m == SW_FULL_MANUAL);
	endfunction

	logic [2:0] mode_field;
	logic freerun_req;
	logic holdover_req;

	assign mode_field = loop_mode_q[LM_MODE_LSB +: 3];
	assign freerun_req = loop_mode_q[LM_FREERUN_BIT];
	assign holdover_req = loop_mode_q[LM_HOLDOVER_BIT] && !freerun_req;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			switch_mode_o <= SW_AUTO_REVERTIVE;
			switch_mode_valid_o <= 1'b1;
			manual_ref_o <= 1'b0;
		end else begin
			switch_mode_o <= mode_field;
			switch_mode_valid_o <= (mode_field <= SW_FULL_MANUAL);
			manual_ref_o <= mode_is_manual(mode_field);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			active_ref_o <= 2'b00;
		else if (mode_is_manual(mode_field))
			active_ref_o <= loop_mode_q[LM_REF_LSB +: 2];
		else
			active_ref_o <= auto_ref_i;
	end

	// the loop logic reads the active reference's profile at a local offset
	always_ff @(posedge clk_i) begin
		if (rst_i)
			profile_dat_o <= 8'h00;
		else if (profile_ofs_i <= PROFILE_LAST_OFS)
			profile_dat_o <= profile_q[active_ref_o][profile_ofs_i];
		else
			profile_dat_o <= 8'h00;
	end

	// ------------------------------------------------------------
	// oscillator tuning source
	// ------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tuning_src_o <= TW_LOOP;
			osc_tuning_word_o <= '0;
			force_unlock_o <= 1'b0;
		end else if (freerun_req) begin
			tuning_src_o <= TW_FREERUN;
			osc_tuning_word_o <= freerun_tuning_word_i;
			force_unlock_o <= 1'b1;
		end else if (holdover_req) begin
			tuning_src_o <= TW_HOLDOVER;
			osc_tuning_word_o <= holdover_tuning_word_i;
			force_unlock_o <= 1'b1;
		end else begin
			tuning_src_o <= TW_LOOP;
			osc_tuning_word_o <= loop_tuning_word_i;
			force_unlock_o <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// power control
	// ------------------------------------------------------------
	// full power-down folds into every sleep line; each clears only when its own bit and bit 0 are both clear
	logic full_pd;
	assign full_pd = power_down_q[PD_FULL_BIT];

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			soft_reset_o <= 1'b0;
			osc_sleep_o <= 1'b0;
			system_clock_input_sleep_o <= 1'b0;
			ref_sleep_o <= 1'b0;
			tdc_sleep_o <= 1'b0;
			output_analog_pll_sleep_o <= 1'b0;
			dist_sleep_o <= 1'b0;
			device_sleep_o <= 1'b0;
		end else begin
			soft_reset_o <= power_down_q[PD_SOFT_RESET_BIT];
			osc_sleep_o <= power_down_q[PD_OSC_BIT] || full_pd;
			system_clock_input_sleep_o <= power_down_q[PD_SYSTEM_CLOCK_INPUT_BIT] || full_pd;
			ref_sleep_o <= power_down_q[PD_REF_BIT] || full_pd;
			tdc_sleep_o <= power_down_q[PD_TDC_BIT] || full_pd;
			output_analog_pll_sleep_o <= power_down_q[PD_OUTPUT_ANALOG_PLL_BIT] || full_pd;
			dist_sleep_o <= power_down_q[PD_DIST_BIT] || full_pd;
			device_sleep_o <= full_pd;
		end
	end

endmodule // operational_control_registers

// [tb/operational_control_registers_asserts.sv]
// concurrent checks on the operational control register bank ports
`timescale 1ns/100ps

module operational_control_registers_asserts
	import opctl_pkg::*;
#(
	parameter int TW_W = 48,
	parameter int ADR_W = 14
) (
	// clock, reset and bus
	input wire logic clk_i, rst_i, we_i, cyc_i, stb_i, ack_o,
	input wire logic [ADR_W-1:0] adr_i,
	input wire logic [31:0] dat_i, dat_o,
	input wire logic [3:0] sel_i,
	// control outputs and their causes
	input wire logic [1:0] auto_ref_i, active_ref_o, tuning_src_o,
	input wire logic [2:0] switch_mode_o,
	input wire logic switch_mode_valid_o, manual_ref_o, force_unlock_o,
	input wire logic [TW_W-1:0] freerun_tuning_word_i, osc_tuning_word_o,
	input wire logic soft_reset_o, osc_sleep_o, system_clock_input_sleep_o, ref_sleep_o,
	input wire logic tdc_sleep_o, output_analog_pll_sleep_o, dist_sleep_o, device_sleep_o
);
	logic tk, pdw, lmw;
	// a write takes effect at its taking edge; outputs follow one edge later
	assign tk = cyc_i && stb_i && !ack_o;
	assign pdw = tk && we_i && sel_i[0] && adr_i == 14'h2800;
	assign lmw = tk && we_i && sel_i[0] && adr_i == 14'h2804;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	soft_reset_a: assert property (pdw |-> ##2 soft_reset_o == $past(dat_i[7], 2))
		else $error("soft reset output wrong");
	unit_sleep_a: assert property (pdw |-> ##2 {osc_sleep_o, system_clock_input_sleep_o, ref_sleep_o, tdc_sleep_o, output_analog_pll_sleep_o,
		dist_sleep_o} == ($past(dat_i[6:1], 2) | {6{$past(dat_i[0], 2)}}))
		else $error("unit sleep outputs wrong");
	device_sleep_a: assert property (pdw |-> ##2 device_sleep_o == $past(dat_i[0], 2))
		else $error("device sleep output wrong");
	free_run_a: assert property (lmw && dat_i[5] |-> ##2 tuning_src_o == TW_FREERUN && force_unlock_o)
		else $error("free run not forced");
	hold_over_a: assert property (lmw && dat_i[6:5] == 2'b10 |-> ##2 tuning_src_o == TW_HOLDOVER)
		else $error("holdover not selected");
	free_word_a: assert property (tuning_src_o == TW_FREERUN && !$past(rst_i)
		|-> osc_tuning_word_o == $past(freerun_tuning_word_i))
		else $error("free run word not used");
	mode_code_a: assert property (lmw |-> ##2 switch_mode_o == $past(dat_i[4:2], 2)
		&& switch_mode_valid_o == ($past(dat_i[4:2], 2) <= 3'h4))
		else $error("switch mode wrong");
	manual_ref_a: assert property (lmw && dat_i[4:2] inside {3'h2, 3'h3, 3'h4}
		|-> ##2 manual_ref_o && active_ref_o == $past(dat_i[1:0], 2))
		else $error("manual reference wrong");
	auto_ref_a: assert property (!manual_ref_o && !$past(rst_i) |-> active_ref_o == $past(auto_ref_i))
		else $error("automatic reference wrong");
	gap_read_a: assert property (tk && !we_i && adr_i[13:10] == 4'h7 && adr_i[7:2] > 6'h26 |=> dat_o == 32'h0)
		else $error("profile gap not empty");
	cover property (pdw && dat_i[0]);
	cover property (lmw && dat_i[6:5] == 2'b11);
	cover property (manual_ref_o);
endmodule // operational_control_registers_asserts

// [tb/test_operational_control_registers.sv]
// self-checking bench for the operational control register bank
`timescale 1ns/100ps

module test_operational_control_registers;
	import opctl_pkg::*;
	logic clk_i = 0, rst_i = 1, we_i = 0, cyc_i = 0, stb_i = 0, ack_o;
	logic [13:0] adr_i = 0;
	logic [31:0] dat_i = 0, dat_o;
	logic [3:0] sel_i = 0;
	logic [5:0] profile_ofs_i = 0, o;
	logic [1:0] auto_ref_i = 0, active_ref_o, tuning_src_o;
	logic [47:0] loop_tuning_word_i = 0, holdover_tuning_word_i = 0, freerun_tuning_word_i = 0, osc_tuning_word_o;
	logic [7:0] profile_dat_o, q, v;
	logic [7:0] d [4];
	logic [2:0] switch_mode_o;
	logic switch_mode_valid_o, manual_ref_o, force_unlock_o, soft_reset_o, osc_sleep_o, system_clock_input_sleep_o;
	logic ref_sleep_o, tdc_sleep_o, output_analog_pll_sleep_o, dist_sleep_o, device_sleep_o;
	int fails = 0, checks = 0, cycles = 0;
	localparam logic [0:3][7:0] CORNER = {8'h60, 8'hFF, 8'h40, 8'h93};

	operational_control_registers dut (.*);

	initial forever #5 clk_i = ~clk_i;

	// ------------------------------------------------------------
	// bus cycle, compare, verdict
	// ------------------------------------------------------------
	task automatic wb(input logic [13:0] a, input logic w, input logic [7:0] wd, output logic [7:0] rd);
		@(posedge clk_i);
		{cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} <= {2'b11, w, a, 24'h0, wd, 4'hF};
		do @(posedge clk_i); while (ack_o !== 1'b1);
		rd = dat_o[7:0];
		{cyc_i, stb_i} <= 2'b00;
		#1;
	endtask
	task automatic chk(input logic [63:0] g, input logic [63:0] e);
		checks++;
		if (g !== e) begin
			fails++;
			$display("FAIL %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic end_sim();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	function automatic logic [9:0] exp_lm(input logic [7:0] x, input logic [1:0] a);
		logic m;
		logic [1:0] s;
		m = x[4:2] inside {3'h2, 3'h3, 3'h4};
		s = x[5] ? 2'h2 : (x[6] ? 2'h1 : 2'h0);
		return {x[4:2], x[4:2] <= 3'h4, m, m ? x[1:0] : a, s, s != 2'h0};
	endfunction

	// hang guard: the whole sequence needs well under this many cycles
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 5000) begin
			fails++;
			end_sim();
		end
	end

	initial begin
		q = $urandom(32'h901F);
		repeat (6) @(posedge clk_i);
		rst_i <= 0;
		for (int k = 0; k < 4; k++)
			for (int i = 0; i < 39; i++) begin
				wb(14'h1C00 + k * 256 + i * 4, 0, 0, q);
				chk(q, PROFILE_RESET[i]);
			end
		wb(14'h2800, 0, 0, q);
		chk(q, 0);
		wb(14'h2804, 0, 0, q);
		chk(q, 0);
		o = $urandom % 39;
		for (int k = 0; k < 4; k++) begin
			d[k] = $urandom;
			wb(14'h1C00 + k * 256 + o * 4, 1, d[k], q);
		end
		wb(14'h1C9C, 1, 8'hFF, q);
		wb(14'h1C9C, 0, 0, q);
		chk(q, 0);
		for (int k = 0; k < 4; k++) begin
			wb(14'h1C00 + k * 256 + o * 4, 0, 0, q);
			chk(q, d[k]);
			wb(14'h2804, 1, 8'h08 | k, q);
			profile_ofs_i <= o;
			repeat (2) @(posedge clk_i);
			#1 chk(profile_dat_o, d[k]);
		end
		profile_ofs_i <= 6'h27;
		repeat (2) @(posedge clk_i);
		#1 chk(profile_dat_o, 0);
		for (int b = 0; b < 9; b++) begin
			v = (b < 8) ? 8'h01 << b : 8'h00;
			wb(14'h2800, 1, v, q);
			chk({soft_reset_o, osc_sleep_o, system_clock_input_sleep_o, ref_sleep_o, tdc_sleep_o, output_analog_pll_sleep_o, dist_sleep_o,
				device_sleep_o}, {v[7], v[6:1] | {6{v[0]}}, v[0]});
			wb(14'h2800, 0, 0, q);
			chk(q, v);
		end
		for (int i = 0; i < 40; i++) begin
			v = (i < 4) ? CORNER[i] : $urandom;
			@(posedge clk_i);
			auto_ref_i <= $urandom;
			loop_tuning_word_i <= {16'($urandom), $urandom};
			holdover_tuning_word_i <= {16'($urandom), $urandom};
			freerun_tuning_word_i <= {16'($urandom), $urandom};
			wb(14'h2804, 1, v, q);
			chk(exp_lm(v, auto_ref_i), {switch_mode_o, switch_mode_valid_o, manual_ref_o, active_ref_o,
				tuning_src_o, force_unlock_o});
			chk(osc_tuning_word_o, v[5] ? freerun_tuning_word_i : (v[6] ? holdover_tuning_word_i :
				loop_tuning_word_i));
			wb(14'h2804, 0, 0, q);
			chk(q, v & 8'h7F);
		end
		end_sim();
	end
endmodule // test_operational_control_registers

bind operational_control_registers operational_control_registers_asserts #(.TW_W(TW_W), .ADR_W(ADR_W)) chk_u (.*);
